// file: verilog/irq_map_pkg.sv
// irq_map_pkg: constants, map and carrier types of the source-to-vector map
// assumes: included before all design files of the interrupt map
package irq_map_pkg;

   // ==========================================================
   // source numbering and table
   // ==========================================================
   localparam int          NUM_IRQ        = 151;
   localparam int          NUM_WORDS      = 10;
   localparam int          NUM_PRI_WORDS  = 38;
   localparam logic [7:0]  VEC_OFFSET     = 8'h08;
   localparam logic [23:0] TABLE_BASE     = 24'h000014;
   localparam logic [23:0] TABLE_LAST     = 24'h0001FE;
   localparam logic [23:0] CODE_START     = 24'h000200;
   localparam logic [7:0]  VEC_LAST       = 8'hF5;
   localparam int          PRI_W          = 3;
   localparam int          PRI_SLOTS      = 4;

   // ==========================================================
   // special sources
   // ==========================================================
   localparam int          IRQ_CAN_A_RX   = 34;
   localparam int          IRQ_CAN_A_EV   = 35;
   localparam int          IRQ_CAN_B_RX   = 55;
   localparam int          IRQ_CAN_B_EV   = 56;
   localparam int          IRQ_CAN_A_TX   = 70;
   localparam int          IRQ_CAN_B_TX   = 71;
   localparam int          IRQ_PMP        = 45;
   localparam int          IRQ_RTC        = 62;
   localparam int          IRQ_DEBUG_APP  = 142;
   localparam int          IRQ_JTAG       = 143;
   localparam int          IRQ_TRIG3      = 150;
   localparam int          UNIMPL_LO      = 100;
   localparam int          UNIMPL_HI      = 141;

   // implemented-source mask, bit n = irq n (reserved slots zero), word 9 first
   localparam logic [159:0] IMPL_MASK =
      {16'h007E, 16'hC000, 16'h0000, 16'h000F, 16'hCF8E,
       16'h2ACE, 16'h5FFF, 16'hBFFF, 16'hFFFF, 16'h7FFF};

   // ==========================================================
   // register bus offsets (word-aligned byte addresses)
   // ==========================================================
   localparam logic [7:0]  OFS_FLAG       = 8'h00;
   localparam logic [7:0]  OFS_ENABLE     = 8'h28;
   localparam logic [7:0]  OFS_FCLR       = 8'h50;
   localparam logic [7:0]  OFS_LATCH      = 8'h78;
   localparam logic [7:0]  OFS_PRI        = 8'h80;
   localparam logic [7:0]  OFS_PRI_END    = 8'h18;

   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [15:0] RST_WORD       = 16'h0000;
   localparam logic [7:0]  RST_VEC        = 8'h00;
   localparam logic [3:0]  RST_LVL        = 4'h0;

   // ==========================================================
   // carriers
   // ==========================================================
   typedef struct packed {
      logic        valid;
      logic [7:0]  vector;
      logic [3:0]  level;
      logic [23:0] address;
   } vec_sel_t;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

endpackage

// file: verilog/irq_flag_bit.sv
// irq_flag_bit: one sticky request flag
// assumes: request pulses and clears come from the same clock
`timescale 1ns/100ps
`default_nettype none
module irq_flag_bit (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic present_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   input  wire logic wr_i,
   input  wire logic wr_val_i,
   // state
   output logic      flag_o
);

   logic flag_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i || !present_i) begin
         flag_ff <= 1'b0;
      end else if (set_i) begin
         flag_ff <= 1'b1;
      end else if (clr_i) begin
         flag_ff <= 1'b0;
      end else if (wr_i) begin
         flag_ff <= wr_val_i;
      end
   end

   assign flag_o = flag_ff;

endmodule
`default_nettype wire

// file: verilog/irq_arbiter.sv
// irq_arbiter: picks highest priority pending source, lowest irq on ties
// assumes: inputs are registered state of the same clock
`timescale 1ns/100ps
`default_nettype none
module irq_arbiter #(
   parameter int N = 151
) (
   // pending state
   input  wire logic [N-1:0]   pend_i,
   input  wire logic [3*N-1:0] pri_i,
   // selection
   output logic                valid_o,
   output logic [7:0]          irq_o,
   output logic [2:0]          level_o
);

   always_comb begin
      valid_o = 1'b0;
      irq_o   = 8'h00;
      level_o = 3'h0;
      for (int i = 0; i < N; i++) begin
         if (pend_i[i] && (!valid_o || pri_i[3*i +: 3] > level_o)) begin
            valid_o = 1'b1;
            irq_o   = 8'(i);
            level_o = pri_i[3*i +: 3];
         end
      end
   end

endmodule
`default_nettype wire

// file: verilog/irq_vector_map.sv
// irq_vector_map: flag, enable and priority arrays with vector selection
// Operation
// - irq 0 is vector 8 at 0x14; vector = irq + 8, two addresses each.
// - flag and enable live in word irq/16, bit irq%16.
// - priority word irq/4 holds four 3-bit fields at nibble slots.
// - reserved slots have no bits and never request.
// - irqs 100 to 141 are unimplemented, no storage.
// - table ends at vector 253 0x1FE; code starts at 0x200.
// - debug application irq 142 word 8 bit 14; jtag irq 143 bit 15.
// - highest source is trigger generator 3, irq 150 word 9 bit 6.
// - can sources exist only when the can parameter is set.
// - parallel port and calendar sources absent in small package.
// - equal priority favours the lower vector address.
// - peripheral request sets a flag; only software clears it.
// - every source has a software 3-bit priority, eight levels.
// - selected vector and level latched into readable fields.
// assumes: classic wishbone master, requests synchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module irq_vector_map #(
   parameter bit HAS_CAN     = 1'b1,
   parameter bit SMALL_PKG   = 1'b0
) (
   // clock and reset
   input  wire logic                                 clk_i,
   input  wire logic                                 rst_i,
   // peripheral requests, bit n = irq n
   input  wire logic [irq_map_pkg::NUM_IRQ-1:0]      req_i,
   // wishbone slave
   input  wire logic                                 cyc_i,
   input  wire logic                                 stb_i,
   input  wire logic                                 we_i,
   input  wire logic [8:0]                           adr_i,
   input  wire logic [3:0]                           sel_i,
   input  wire logic [31:0]                          dat_i,
   output logic [31:0]                               dat_o,
   output logic                                      ack_o,
   // to cpu core
   output irq_map_pkg::vec_sel_t                     vec_o,
   output logic                                      irq_o
);

   localparam int N  = irq_map_pkg::NUM_IRQ;
   localparam int NW = irq_map_pkg::NUM_WORDS;
   localparam int NP = irq_map_pkg::NUM_PRI_WORDS;

   // ==========================================================
   // presence of each source
   // ==========================================================
   logic [N-1:0] present;

   always_comb begin
      present = irq_map_pkg::IMPL_MASK[N-1:0];
      for (int i = irq_map_pkg::UNIMPL_LO; i <= irq_map_pkg::UNIMPL_HI; i++) begin
         present[i] = 1'b0;
      end
      present[irq_map_pkg::IRQ_DEBUG_APP] = 1'b1;
      present[irq_map_pkg::IRQ_JTAG]      = 1'b1;
      present[irq_map_pkg::IRQ_TRIG3]     = 1'b1;
      if (!HAS_CAN) begin
         present[irq_map_pkg::IRQ_CAN_A_RX] = 1'b0;
         present[irq_map_pkg::IRQ_CAN_A_EV] = 1'b0;
         present[irq_map_pkg::IRQ_CAN_B_RX] = 1'b0;
         present[irq_map_pkg::IRQ_CAN_B_EV] = 1'b0;
         present[irq_map_pkg::IRQ_CAN_A_TX] = 1'b0;
         present[irq_map_pkg::IRQ_CAN_B_TX] = 1'b0;
      end
      if (SMALL_PKG) begin
         present[irq_map_pkg::IRQ_PMP] = 1'b0;
         present[irq_map_pkg::IRQ_RTC] = 1'b0;
      end
   end

   // ==========================================================
   // bus decode
   // ==========================================================
   logic       bus_req;
   logic       wr_go;
   logic       take_go;
   logic [7:0] word_idx;
   logic       hit_flag;
   logic       hit_en;
   logic       hit_fclr;
   logic       hit_pri;
   logic       hit_latch;
   logic [7:0] pri_idx;
   logic       lo_sel;
   logic       hi_sel;

   irq_map_pkg::bus_state_t bus_state_ff;
   irq_map_pkg::bus_state_t nxt_bus_state;

   // request taken only while idle, so one take per cycle of the master
   assign bus_req  = cyc_i && stb_i;
   assign take_go  = bus_req && (bus_state_ff == irq_map_pkg::BUS_IDLE);
   assign wr_go    = take_go && we_i;

   // word index and region hits, byte address on word boundaries
   assign word_idx = {1'b0, adr_i[8:2]};
   assign pri_idx  = word_idx - {2'b00, irq_map_pkg::OFS_PRI[7:2]};
   assign lo_sel   = sel_i[0];
   assign hi_sel   = sel_i[1];
   assign hit_flag = adr_i < 9'(irq_map_pkg::OFS_ENABLE);
   assign hit_en   = adr_i >= 9'(irq_map_pkg::OFS_ENABLE) && adr_i < 9'(irq_map_pkg::OFS_FCLR);
   assign hit_fclr = adr_i >= 9'(irq_map_pkg::OFS_FCLR) && adr_i < 9'(irq_map_pkg::OFS_LATCH);
   assign hit_latch = adr_i[8:2] == {1'b0, irq_map_pkg::OFS_LATCH[7:2]};
   // priority words run past the 8-bit byte range
   assign hit_pri  = adr_i >= 9'(irq_map_pkg::OFS_PRI) && pri_idx < 8'(NP);

   // one ack per request, raised the cycle after the take, dropped the cycle after
   always_comb begin
      case (bus_state_ff)
         irq_map_pkg::BUS_IDLE: nxt_bus_state = bus_req ? irq_map_pkg::BUS_ACK
                                                         : irq_map_pkg::BUS_IDLE;
         irq_map_pkg::BUS_ACK:  nxt_bus_state = irq_map_pkg::BUS_IDLE;
         default:               nxt_bus_state = irq_map_pkg::BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_ff <= irq_map_pkg::BUS_IDLE;
      end else begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   assign ack_o = bus_state_ff == irq_map_pkg::BUS_ACK;

   // ==========================================================
   // flag, enable and priority storage
   // ==========================================================
   logic [N-1:0]   flag;
   logic [N-1:0]   enable_ff;
   logic [3*N-1:0] pri_ff;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_src
         localparam int W = g / 16;
         localparam int B = g % 16;
         localparam int PW = g / irq_map_pkg::PRI_SLOTS;
         localparam int PS = g % irq_map_pkg::PRI_SLOTS;
         logic wsel;
         logic wbit;
         assign wsel = (B < 8) ? lo_sel : hi_sel;
         assign wbit = dat_i[B];

         irq_flag_bit u_flag (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .present_i (present[g]),
            .set_i     (req_i[g]),
            .clr_i     (wr_go && hit_fclr && word_idx == 8'(W + 20) && wsel && wbit),
            .wr_i      (wr_go && hit_flag && word_idx == 8'(W) && wsel),
            .wr_val_i  (wbit),
            .flag_o    (flag[g])
         );

         always_ff @(posedge clk_i) begin
            if (rst_i || !present[g]) begin
               enable_ff[g] <= 1'b0;
            end else if (wr_go && hit_en && word_idx == 8'(W + 10) && wsel) begin
               enable_ff[g] <= wbit;
            end
         end

         always_ff @(posedge clk_i) begin
            if (rst_i || !present[g]) begin
               pri_ff[3*g +: 3] <= 3'h0;
            end else if (wr_go && hit_pri && pri_idx == 8'(PW)
                         && ((PS < 2) ? lo_sel : hi_sel)) begin
               pri_ff[3*g +: 3] <= dat_i[4*PS +: 3];
            end
         end
      end
   endgenerate

   // ==========================================================
   // selection and latching
   // ==========================================================
   logic       sel_valid;
   logic [7:0] sel_irq;
   logic [2:0] sel_lvl;

   irq_arbiter #(
      .N (N)
   ) u_arb (
      .pend_i  (flag & enable_ff & present),
      .pri_i   (pri_ff),
      .valid_o (sel_valid),
      .irq_o   (sel_irq),
      .level_o (sel_lvl)
   );

   irq_map_pkg::vec_sel_t nxt_vec;
   irq_map_pkg::vec_sel_t vec_ff;

   // vector = irq + 8, address = base + 2*irq
   always_comb begin
      nxt_vec.valid   = sel_valid;
      nxt_vec.vector  = irq_map_pkg::RST_VEC;
      nxt_vec.level   = irq_map_pkg::RST_LVL;
      // idle address points past the table
      nxt_vec.address = irq_map_pkg::CODE_START;
      if (sel_valid) begin
         nxt_vec.vector  = sel_irq + irq_map_pkg::VEC_OFFSET;
         nxt_vec.level   = {1'b0, sel_lvl};
         nxt_vec.address = irq_map_pkg::TABLE_BASE + {15'h0000, sel_irq, 1'b0};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vec_ff.valid   <= 1'b0;
         vec_ff.vector  <= irq_map_pkg::RST_VEC;
         vec_ff.level   <= irq_map_pkg::RST_LVL;
         vec_ff.address <= irq_map_pkg::CODE_START;
      end else begin
         vec_ff <= nxt_vec;
      end
   end

   // cpu side outputs straight from the latch
   assign vec_o = vec_ff;
   assign irq_o = vec_ff.valid;

   // ==========================================================
   // word views of the arrays
   // ==========================================================
   logic [15:0] flag_word   [NW];
   logic [15:0] enable_word [NW];
   logic [15:0] pri_word    [NP];

   // sixteen sources per flag and enable word
   always_comb begin
      for (int w = 0; w < NW; w++) begin
         flag_word[w]   = irq_map_pkg::RST_WORD;
         enable_word[w] = irq_map_pkg::RST_WORD;
      end
      for (int i = 0; i < N; i++) begin
         flag_word[i / 16][i % 16]   = flag[i];
         enable_word[i / 16][i % 16] = enable_ff[i];
      end
   end

   // four fields per priority word, gap bits read zero
   always_comb begin
      for (int w = 0; w < NP; w++) begin
         pri_word[w] = irq_map_pkg::RST_WORD;
      end
      for (int i = 0; i < N; i++) begin
         pri_word[i / 4][4 * (i % 4) +: 3] = pri_ff[3*i +: 3];
      end
   end

   // ==========================================================
   // read data
   // ==========================================================
   logic [7:0]  en_idx;
   logic [31:0] nxt_dat;
   logic [31:0] dat_ff;

   // enable words follow the flag words
   assign en_idx = word_idx - 8'(NW);

   // absent bits and unmapped words read zero
   always_comb begin
      nxt_dat = 32'h00000000;
      if (hit_flag) begin
         nxt_dat[15:0] = flag_word[word_idx[3:0]];
      end else if (hit_en) begin
         nxt_dat[15:0] = enable_word[en_idx[3:0]];
      end else if (hit_pri) begin
         nxt_dat[15:0] = pri_word[pri_idx[5:0]];
      end else if (hit_latch) begin
         nxt_dat = {20'h00000, vec_ff.level, vec_ff.vector};
      end
   end

   // read data held until the next taken request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= 32'h00000000;
      end else if (take_go) begin
         dat_ff <= nxt_dat;
      end
   end

   assign dat_o = dat_ff;

endmodule
`default_nettype wire

// file: sim/irq_vector_map_assertions.sv
// irq_vector_map_assertions: port-level properties of the vector map
// assumes: bound to irq_vector_map, single clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module irq_vector_map_assertions (
   // clock and reset
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   // bus
   input wire logic                  cyc_i,
   input wire logic                  stb_i,
   input wire logic                  we_i,
   input wire logic [31:0]           dat_o,
   input wire logic                  ack_o,
   // to cpu core
   input wire irq_map_pkg::vec_sel_t vec_o,
   input wire logic                  irq_o
);
   // ==========================================================
   // properties
   // ==========================================================
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_lat;
      cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
   property p_no_ack_idle;
      !(cyc_i && stb_i) |=> !ack_o;
   endproperty
   a_no_ack_idle: assert property (p_no_ack_idle) else $error("ack without request");
   property p_irq_valid;
      irq_o == vec_o.valid;
   endproperty
   a_irq_valid: assert property (p_irq_valid) else $error("irq and valid differ");
   property p_addr_map;
      vec_o.valid |-> vec_o.address == irq_map_pkg::TABLE_BASE
         + {15'h0000, vec_o.vector - irq_map_pkg::VEC_OFFSET, 1'b0};
   endproperty
   a_addr_map: assert property (p_addr_map) else $error("vector address off");
   property p_vec_impl;
      vec_o.valid |-> vec_o.vector >= 8'h08
         && irq_map_pkg::IMPL_MASK[vec_o.vector - irq_map_pkg::VEC_OFFSET];
   endproperty
   a_vec_impl: assert property (p_vec_impl) else $error("reserved vector presented");
   property p_table_end;
      vec_o.valid |-> vec_o.vector <= 8'h9E && vec_o.address <= irq_map_pkg::TABLE_LAST;
   endproperty
   a_table_end: assert property (p_table_end) else $error("vector beyond last source");
   property p_level;
      vec_o.valid |-> vec_o.level[3] == 1'b0;
   endproperty
   a_level: assert property (p_level) else $error("level above seven");
   property p_upper_zero;
      ack_o |-> dat_o[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
   // main scenarios
   c_write: cover property (ack_o && we_i);
   c_irq: cover property ($rose(irq_o));
   c_lvl7: cover property (vec_o.valid && vec_o.level == 4'h7);
endmodule
bind irq_vector_map irq_vector_map_assertions u_irq_vector_map_assertions (.clk_i, .rst_i,
   .cyc_i, .stb_i, .we_i, .dat_o, .ack_o, .vec_o, .irq_o);
`default_nettype wire

// file: sim/cpu_core_model.sv
// cpu_core_model: cpu side, takes the presented vector and level
// assumes: vec_o and irq_o registered on clk_i
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
   // clock and reset
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   // from the map
   input wire irq_map_pkg::vec_sel_t vec_i,
   input wire logic                  irq_i
);
   logic [7:0] seen_vec_ff;
   logic [3:0] seen_lvl_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seen_vec_ff <= 8'h00;
         seen_lvl_ff <= 4'h0;
      end else if (irq_i) begin
         seen_vec_ff <= vec_i.vector;
         seen_lvl_ff <= vec_i.level;
      end
   end
endmodule
`default_nettype wire

// file: sim/irq_vector_map_test.sv
// irq_vector_map_test: directed bench for the source-to-vector map
// assumes: wishbone ack one cycle after take, vec_o one cycle after flag
`timescale 1ns/100ps
`default_nettype none
module irq_vector_map_test;
   logic                   clk_i = 1'b0;
   logic                   rst_i = 1'b1;
   logic [150:0]           req_i = '0;
   logic                   cyc_i = 1'b0;
   logic                   stb_i = 1'b0;
   logic                   we_i = 1'b0;
   logic [8:0]             adr_i = 9'h000;
   logic [3:0]             sel_i = 4'h0;
   logic [31:0]            dat_i = 32'h00000000;
   logic [31:0]            dat_o;
   logic [31:0]            dat_o_small;
   logic                   ack_o;
   irq_map_pkg::vec_sel_t  vec_o;
   logic                   irq_o;
   int                     n_mismatch = 0;
   int                     check_count = 0;
   int                     cycles = 0;
   logic [31:0]            rd;
   irq_vector_map u_irq_vector_map (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .vec_o(vec_o), .irq_o(irq_o));
   cpu_core_model u_cpu_core_model (.clk_i(clk_i), .rst_i(rst_i), .vec_i(vec_o), .irq_i(irq_o));
   // small variant: no can sources, no parallel port or calendar
   irq_vector_map #(.HAS_CAN(1'b0), .SMALL_PKG(1'b1)) u_irq_vector_map_small (.clk_i(clk_i),
      .rst_i(rst_i), .req_i(req_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o_small), .ack_o(), .vec_o(), .irq_o());
   // ==========================================================
   // helpers
   // ==========================================================
   always #5 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
         n_mismatch++;
      end
   endtask
   // one classic cycle, entered just after a rising edge
   task automatic bus(input logic we, input logic [8:0] a, input logic [15:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= we;
      adr_i <= a;
      sel_i <= 4'h3;
      dat_i <= {16'h0000, d};
      // wait for ack; no limit here, only the bench timeout ends a wait that never sees ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic pulse(input logic [150:0] m);
      req_i <= m;
      @(posedge clk_i);
      req_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic vec_is(input logic [7:0] v, input logic [3:0] l, input logic [23:0] a);
      repeat (2) @(posedge clk_i);
      chk({31'h00000000, irq_o}, 32'h00000001, "irq");
      chk({20'h00000, vec_o.level, vec_o.vector}, {20'h00000, l, v}, "level vector");
      chk({8'h00, vec_o.address}, {8'h00, a}, "address");
   endtask
   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_reset;
      bus(1'b0, 9'h000, 16'h0000);
      chk(rd, 32'h00000000, "flag rst");
      bus(1'b0, 9'h028, 16'h0000);
      chk(rd, 32'h00000000, "enable rst");
      bus(1'b0, 9'h080, 16'h0000);
      chk(rd, 32'h00000000, "prio rst");
      bus(1'b0, 9'h078, 16'h0000);
      chk(rd, 32'h00000000, "latch rst");
      chk({8'h00, vec_o.address}, 32'h00000200, "idle address");
      $display("test reset done");
   endtask
   task automatic t_map;
      int ids[9] = '{0, 15, 32, 46, 100, 141, 142, 143, 150};
      logic [15:0] e;
      foreach (ids[i]) begin
         e = 16'h0000;
         e[ids[i] % 16] = irq_map_pkg::IMPL_MASK[ids[i]];
         pulse(151'(1) << ids[i]);
         bus(1'b0, 9'(4 * (ids[i] / 16)), 16'h0000);
         chk(rd, {16'h0000, e}, "flag place");
         bus(1'b1, 9'(9'h050 + 4 * (ids[i] / 16)), 16'hFFFF);
         bus(1'b0, 9'(4 * (ids[i] / 16)), 16'h0000);
         chk(rd, 32'h00000000, "flag clear");
      end
      $display("test map done");
   endtask
   task automatic t_variant;
      pulse((151'(1) << irq_map_pkg::IRQ_CAN_A_RX) | (151'(1) << irq_map_pkg::IRQ_PMP)
         | (151'(1) << irq_map_pkg::IRQ_RTC));
      bus(1'b0, 9'h008, 16'h0000);
      chk(rd, 32'h00002004, "full can and port flags");
      chk(dat_o_small, 32'h00000000, "small can and port flags");
      bus(1'b0, 9'h00C, 16'h0000);
      chk(rd, 32'h00004000, "full calendar flag");
      chk(dat_o_small, 32'h00000000, "small calendar flag");
      bus(1'b1, 9'h058, 16'hFFFF);
      bus(1'b1, 9'h05C, 16'hFFFF);
      $display("test variant done");
   endtask
   task automatic t_regs;
      bus(1'b1, 9'h028, 16'hFFFF);
      bus(1'b0, 9'h028, 16'h0000);
      chk(rd, 32'h00007FFF, "enable reserved bit");
      bus(1'b1, 9'h08C, 16'hFFFF);
      bus(1'b0, 9'h08C, 16'h0000);
      chk(rd, 32'h00000777, "prio fields");
      bus(1'b1, 9'h07C, 16'hFFFF);
      bus(1'b0, 9'h07C, 16'h0000);
      chk(rd, 32'h00000000, "unmapped");
      bus(1'b1, 9'h028, 16'h0000);
      bus(1'b1, 9'h08C, 16'h0000);
      $display("test regs done");
   endtask
   task automatic t_vector;
      pulse((151'(1) << 150) | 151'h9);
      bus(1'b1, 9'h028, 16'h0009);
      bus(1'b1, 9'h04C, 16'h0040);
      bus(1'b1, 9'h080, 16'h5000);
      vec_is(8'h0B, 4'h5, 24'h00001A);
      bus(1'b0, 9'h078, 16'h0000);
      chk(rd, 32'h0000050B, "latched");
      chk({24'h000000, u_cpu_core_model.seen_vec_ff}, 32'h0000000B, "cpu vector");
      bus(1'b1, 9'h080, 16'h0000);
      vec_is(8'h08, 4'h0, 24'h000014);
      bus(1'b1, 9'h080, 16'h0007);
      vec_is(8'h08, 4'h7, 24'h000014);
      bus(1'b1, 9'h050, 16'h0009);
      vec_is(8'h9E, 4'h0, 24'h000140);
      bus(1'b1, 9'h114, 16'h0300);
      vec_is(8'h9E, 4'h3, 24'h000140);
      bus(1'b0, 9'h114, 16'h0000);
      chk(rd, 32'h00000300, "top prio word");
      bus(1'b1, 9'h074, 16'h0040);
      repeat (2) @(posedge clk_i);
      chk({31'h00000000, irq_o}, 32'h00000000, "irq after clear");
      $display("test vector done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // cut a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_map();
      t_variant();
      t_regs();
      t_vector();
      summarize();
   end
endmodule
`default_nettype wire
